// File: src/scm_pkg.sv
package scm_pkg;
   // ****************************************
   // Register map
   // ****************************************
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam logic [7:0] OFS_COLOR_ZERO = 8'h3C;
   localparam logic [7:0] OFS_COLOR_ONE = 8'h3D;
   localparam logic [7:0] OFS_COLOR_TWO = 8'h3E;
   localparam logic [7:0] OFS_COLOR_THREE = 8'h3F;
   localparam logic [7:0] OFS_FUNCTION = 8'h38;
   localparam logic [7:0] OFS_ENABLE = 8'h40;
   localparam logic [7:0] OFS_STATUS = 8'h41;
   // ****************************************
   // Fields and reset values
   // ****************************************
   localparam int SHADE_W = 4;
   localparam int NUM_ENTRIES = 4;
   localparam int FN_SCHEME_BIT = 0;
   localparam int FN_SELECT_BIT = 1;
   localparam int FN_HDBL_BIT = 2;
   localparam int FN_VDBL_BIT = 3;
   localparam logic [3:0] FN_MASK = 4'h0_F;
   localparam logic [3:0] SHADE_RESET = 4'h0;
   localparam logic [3:0] FN_RESET = 4'h0;
   localparam int FETCH_W = 32;
   localparam int PIX_PER_FETCH_SPRITE = 8;
   localparam int PIX_PER_FETCH_CURSOR = 16;
   typedef enum logic [1:0] {SCM_SPRITE4, SCM_SPRITE3T, SCM_CURSOR} scm_mode_t;
   typedef enum {SCM_IDLE, SCM_SHIFT} scm_state_t;
endpackage : scm_pkg

// File: src/scm_palette.sv
`timescale 1ns/100ps
// Four 4-bit shade entries, one write port, registered read port
module scm_palette (
   input wire logic CORE_CLK,                                 // Pixel clock
   input wire logic NRST,                                     // Async reset, low
   input wire logic wr_en,                                    // Write strobe
   input wire logic [1:0] wr_idx,                             // Entry written
   input wire logic [scm_pkg::SHADE_W-1:0] wr_data,           // Shade written
   input wire logic [1:0] rd_idx,                             // Entry read back
   output logic [scm_pkg::SHADE_W-1:0] rd_data,               // Registered read
   output logic [4*scm_pkg::SHADE_W-1:0] all_entries          // All entries flat
);
   import scm_pkg::*;
   logic [SHADE_W-1:0] mem_q [NUM_ENTRIES];
   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         for (int i = 0; i < NUM_ENTRIES; i++) begin
            mem_q[i] <= SHADE_RESET;
         end
         rd_data <= SHADE_RESET;
      end else begin
         if (wr_en) begin
            mem_q[wr_idx] <= wr_data;
         end
         rd_data <= mem_q[rd_idx];
      end
   end
   assign all_entries = {mem_q[3], mem_q[2], mem_q[1], mem_q[0]};
endmodule : scm_palette

// File: src/scm_color_mapper.sv
`timescale 1ns/100ps
// What this block does
// - Four writable 4-bit shade entries, indexed by the 2-bit pixel.
// - Cursor mode uses entry 0 as background shade.
// - Cursor mode uses entry 1 as foreground shade.
// - Shades skip the gray lookup table; 4 bits pick one of 16 grays.
// - Sprite and cursor share one datapath; only one shown at a time.
// - Mode 00: pixel values 0..3 show entries 0..3.
// - Mode 01: pixel 0 is transparent, 1..3 show entries 1..3.
// - Cursor: 00 background, 01 foreground, 10 screen, 11 inverted screen.
// - Planes 0/2 give bit 0, 1/3 bit 1; B7 is the lowest pixel.
// - Select bit picks sprite at 0, cursor at 1, only when enabled.
// - Each fetch is 32 bits: eight sprite or sixteen cursor pixels.
module scm_color_mapper (
   input wire logic CORE_CLK,                                 // Pixel clock
   input wire logic NRST,                                     // Async reset, low
   input wire logic [scm_pkg::ADDR_W-1:0] REG_ADDR,           // Register address
   input wire logic [scm_pkg::DATA_W-1:0] REG_WDATA,          // Write data
   input wire logic REG_WR,                                   // Write strobe
   input wire logic REG_RD,                                   // Read strobe
   output logic [scm_pkg::DATA_W-1:0] REG_RDATA,              // Read data, next cycle
   input wire logic [scm_pkg::FETCH_W-1:0] FETCH_DATA,        // Pattern word
   input wire logic FETCH_VALID,                              // Pattern word present
   output logic FETCH_READY,                                  // Ready for a new word
   input wire logic PIX_ADVANCE,                              // Display wants a pixel
   input wire logic OVL_ACTIVE,                               // Pixel inside overlay
   input wire logic [scm_pkg::SHADE_W-1:0] SCREEN_SHADE,      // Underlying screen shade
   output logic [scm_pkg::SHADE_W-1:0] PIX_SHADE,             // Merged output shade
   output logic PIX_FROM_OVERLAY                              // Shade came from palette
);
   import scm_pkg::*;

   // ****************************************
   // Register file
   // ****************************************
   logic [3:0] function_q;
   logic enable_q;
   logic rd_pend_q;
   logic [DATA_W-1:0] misc_rdata_q;
   logic [DATA_W-1:0] misc_rdata_d;
   logic [SHADE_W-1:0] pal_rdata;
   logic [4*SHADE_W-1:0] pal_flat;
   wire hit_palette = (REG_ADDR[7:2] == OFS_COLOR_ZERO[7:2]);
   wire pal_wr = REG_WR && hit_palette;
   wire fn_wr = REG_WR && (REG_ADDR == OFS_FUNCTION);
   wire en_wr = REG_WR && (REG_ADDR == OFS_ENABLE);
   logic rd_pal_q;

   scm_palette u_palette (
      .CORE_CLK(CORE_CLK),
      .NRST(NRST),
      .wr_en(pal_wr),
      .wr_idx(REG_ADDR[1:0]),
      .wr_data(REG_WDATA[SHADE_W-1:0]),
      .rd_idx(REG_ADDR[1:0]),
      .rd_data(pal_rdata),
      .all_entries(pal_flat)
   );

   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         function_q <= FN_RESET;
         enable_q <= 1'b0;
      end else begin
         if (fn_wr) begin
            function_q <= REG_WDATA[3:0] & FN_MASK;
         end
         if (en_wr) begin
            enable_q <= REG_WDATA[0];
         end
      end
   end

   // Status: enable, effective cursor mode, pattern word held
   logic busy_q;
   wire cursor_sel = enable_q && function_q[FN_SELECT_BIT];
   always_comb begin
      misc_rdata_d = '0;
      case (REG_ADDR)
         OFS_FUNCTION: misc_rdata_d = {4'h0, function_q};
         OFS_ENABLE: misc_rdata_d = {7'h00, enable_q};
         OFS_STATUS: misc_rdata_d = {5'h00, busy_q, cursor_sel, enable_q};
         default: misc_rdata_d = '0;
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         rd_pend_q <= 1'b0;
         rd_pal_q <= 1'b0;
         misc_rdata_q <= '0;
      end else begin
         rd_pend_q <= REG_RD;
         rd_pal_q <= REG_RD && hit_palette;
         misc_rdata_q <= REG_RD ? misc_rdata_d : '0;
      end
   end
   // Unmapped reads and non-read cycles give zero
   assign REG_RDATA = !rd_pend_q ? '0 : rd_pal_q ? {4'h0, pal_rdata} : misc_rdata_q;

   // ****************************************
   // Pattern unpacking
   // ****************************************
   // Word layout: byte 0 is plane 0 at X, bytes 1..3 planes 1..3 at X,
   // so pixels 0-7 of a fetch come from planes 0/1 and pixels 8-15 from planes 2/3.
   function automatic logic [1:0] pattern_pixel(input logic [FETCH_W-1:0] w, input logic [3:0] n);
      logic [7:0] lo;
      logic [7:0] hi;
      logic [2:0] b;
      lo = n[3] ? w[23:16] : w[7:0];
      hi = n[3] ? w[31:24] : w[15:8];
      b = 3'd7 - n[2:0];
      return {hi[b], lo[b]};
   endfunction : pattern_pixel

   scm_state_t state_q;
   logic [FETCH_W-1:0] word_q;
   logic [3:0] pix_idx_q;
   wire cursor_fetch = cursor_sel;
   // Sprite pixels are 2 bits each from 8 bits per plane pair; the cursor
   // sees 16 pixels, the sprite only the first 8 of each word.
   wire [3:0] last_idx = cursor_fetch ? 4'(PIX_PER_FETCH_CURSOR - 1) : 4'(PIX_PER_FETCH_SPRITE - 1);
   wire consume = (state_q == SCM_SHIFT) && PIX_ADVANCE && OVL_ACTIVE;
   wire word_done = consume && (pix_idx_q == last_idx);
   assign FETCH_READY = (state_q == SCM_IDLE) || word_done;
   assign busy_q = (state_q == SCM_SHIFT);

   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         state_q <= SCM_IDLE;
         word_q <= '0;
         pix_idx_q <= 4'h0;
      end else begin
         case (state_q)
            SCM_IDLE: begin
               if (FETCH_VALID && enable_q) begin
                  word_q <= FETCH_DATA;
                  pix_idx_q <= 4'h0;
                  state_q <= SCM_SHIFT;
               end
            end
            SCM_SHIFT: begin
               if (!enable_q) begin
                  state_q <= SCM_IDLE;
               end else if (word_done) begin
                  pix_idx_q <= 4'h0;
                  if (FETCH_VALID) begin
                     word_q <= FETCH_DATA;
                  end else begin
                     state_q <= SCM_IDLE;
                  end
               end else if (consume) begin
                  pix_idx_q <= pix_idx_q + 4'h1;
               end
            end
            default: state_q <= SCM_IDLE;
         endcase
      end
   end

   // ****************************************
   // Colour decode, one shared path
   // ****************************************
   function automatic logic [SHADE_W-1:0] entry(input logic [4*SHADE_W-1:0] f, input logic [1:0] i);
      return f[i*SHADE_W +: SHADE_W];
   endfunction : entry

   wire [1:0] cur_pix = pattern_pixel(word_q, pix_idx_q);
   wire scm_mode_t mode = cursor_sel ? SCM_CURSOR :
                          function_q[FN_SCHEME_BIT] ? SCM_SPRITE3T : SCM_SPRITE4;
   wire [SHADE_W-1:0] overlay_shade_zero_background = entry(pal_flat, 2'd0);
   wire [SHADE_W-1:0] overlay_shade_one_foreground = entry(pal_flat, 2'd1);
   logic [SHADE_W-1:0] shade_d;
   logic from_ovl_d;

   always_comb begin
      shade_d = SCREEN_SHADE;
      from_ovl_d = 1'b0;
      if (busy_q && OVL_ACTIVE) begin
         case (mode)
            SCM_SPRITE4: begin
               shade_d = entry(pal_flat, cur_pix);
               from_ovl_d = 1'b1;
            end
            SCM_SPRITE3T: begin
               if (cur_pix != 2'b00) begin
                  shade_d = entry(pal_flat, cur_pix);
                  from_ovl_d = 1'b1;
               end
            end
            SCM_CURSOR: begin
               case (cur_pix)
                  2'b00: begin
                     shade_d = overlay_shade_zero_background;
                     from_ovl_d = 1'b1;
                  end
                  2'b01: begin
                     shade_d = overlay_shade_one_foreground;
                     from_ovl_d = 1'b1;
                  end
                  2'b10: shade_d = SCREEN_SHADE;
                  default: shade_d = ~SCREEN_SHADE;
               endcase
            end
            default: shade_d = SCREEN_SHADE;
         endcase
      end
   end

   // Shade goes straight to the panel, no gray table in the path
   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         PIX_SHADE <= SHADE_RESET;
         PIX_FROM_OVERLAY <= 1'b0;
      end else if (PIX_ADVANCE) begin
         PIX_SHADE <= shade_d;
         PIX_FROM_OVERLAY <= from_ovl_d;
      end
   end
endmodule : scm_color_mapper

// File: verif/scm_monitor.sv
`timescale 1ns/100ps
// ****
// Port checks
// ****
module scm_monitor (
   input wire logic CORE_CLK, // Clock
   input wire logic NRST, // Reset
   input wire logic [7:0] REG_ADDR, // Addr
   input wire logic [7:0] REG_WDATA, // Wdata
   input wire logic REG_WR, // Write
   input wire logic REG_RD, // Read
   input wire logic [7:0] REG_RDATA, // Rdata
   input wire logic PIX_ADVANCE, // Advance
   input wire logic OVL_ACTIVE, // In area
   input wire logic [3:0] SCREEN_SHADE, // Screen
   input wire logic [3:0] PIX_SHADE, // Shade
   input wire logic PIX_FROM_OVERLAY // Source
);
   import scm_pkg::*;
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!NRST);
   sequence s_entry_wr_rd;
      REG_WR && REG_ADDR[7:2] == 6'h0F ##1 REG_RD && REG_ADDR == $past(REG_ADDR);
   endsequence
   sequence s_fn_wr_rd;
      REG_WR && REG_ADDR == OFS_FUNCTION ##1 REG_RD && REG_ADDR == OFS_FUNCTION;
   endsequence
   AST_ENTRY_ROUNDTRIP: assert property (s_entry_wr_rd |=> REG_RDATA == ($past(REG_WDATA, 2) & 8'h0F))
      else $error("entry readback differs");
   AST_FN_ROUNDTRIP: assert property (s_fn_wr_rd |=> REG_RDATA == ($past(REG_WDATA, 2) & 8'h0F))
      else $error("function readback differs");
   AST_ENTRY_UPPER: assert property (REG_RD && REG_ADDR[7:2] == 6'h0F |=> REG_RDATA[7:4] == 4'h0)
      else $error("entry upper bits set");
   AST_STATUS_SEL: assert property (REG_RD && REG_ADDR == OFS_STATUS |=> !(REG_RDATA[1] && !REG_RDATA[0]))
      else $error("cursor effective while off");
   AST_RDATA_IDLE: assert property (!REG_RD |=> REG_RDATA == 8'h00)
      else $error("read data without read");
   AST_UNMAPPED: assert property (REG_RD && REG_ADDR < OFS_FUNCTION |=> REG_RDATA == 8'h00)
      else $error("unmapped read nonzero");
   AST_SHADE_HOLD: assert property (!PIX_ADVANCE |=> $stable(PIX_SHADE) && $stable(PIX_FROM_OVERLAY))
      else $error("shade moved without advance");
   AST_OUTSIDE_SCREEN: assert property (PIX_ADVANCE && !OVL_ACTIVE |=>
      PIX_SHADE == $past(SCREEN_SHADE) && !PIX_FROM_OVERLAY) else $error("outside pixel not screen");
endmodule : scm_monitor
bind scm_color_mapper scm_monitor scm_monitor_inst (.CORE_CLK(CORE_CLK), .NRST(NRST),
   .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
   .PIX_ADVANCE(PIX_ADVANCE), .OVL_ACTIVE(OVL_ACTIVE), .SCREEN_SHADE(SCREEN_SHADE),
   .PIX_SHADE(PIX_SHADE), .PIX_FROM_OVERLAY(PIX_FROM_OVERLAY));

// File: verif/scm_fetch_model.sv
`timescale 1ns/100ps
// ****
// Video memory fetch side
// ****
module scm_fetch_model (
   input wire logic CORE_CLK, // Clock
   input wire logic NRST, // Reset
   input wire logic FETCH_READY, // Taker ready
   input wire logic offer, // Offer pulse
   input wire logic [31:0] word, // Word offered
   output logic FETCH_VALID, // Word present
   output logic [31:0] FETCH_DATA // Pattern word
);
   logic [31:0] last_q;
   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         FETCH_VALID <= 1'b0;
         last_q <= '0;
      end else if (FETCH_VALID && FETCH_READY) begin
         FETCH_VALID <= 1'b0;
      end else if (offer && !FETCH_VALID) begin
         FETCH_VALID <= 1'b1;
         last_q <= word;
      end
   end
   // Idle bus shows inverted data, never a stale word
   assign FETCH_DATA = FETCH_VALID ? last_q : ~last_q;
endmodule : scm_fetch_model

// File: verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   import scm_pkg::*;
   logic CORE_CLK = 1'b0, NRST = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0, PIX_ADVANCE = 1'b0;
   logic OVL_ACTIVE = 1'b0, offer = 1'b0, rd_seen = 1'b0, px_seen = 1'b0;
   logic FETCH_VALID, FETCH_READY, PIX_FROM_OVERLAY;
   logic [7:0] REG_ADDR = '0, REG_WDATA = '0, REG_RDATA, got;
   logic [3:0] SCREEN_SHADE = '0, PIX_SHADE, s, sh [4];
   logic [31:0] word = '0, w, FETCH_DATA;
   logic [7:0] exp_q [$];
   int errors = 0, samples_checked = 0, cycles = 0;
   always #5 CORE_CLK = ~CORE_CLK;
   scm_color_mapper scm_color_mapper_inst (.CORE_CLK(CORE_CLK), .NRST(NRST), .REG_ADDR(REG_ADDR),
      .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
      .FETCH_DATA(FETCH_DATA), .FETCH_VALID(FETCH_VALID), .FETCH_READY(FETCH_READY),
      .PIX_ADVANCE(PIX_ADVANCE), .OVL_ACTIVE(OVL_ACTIVE), .SCREEN_SHADE(SCREEN_SHADE),
      .PIX_SHADE(PIX_SHADE), .PIX_FROM_OVERLAY(PIX_FROM_OVERLAY));
   scm_fetch_model scm_fetch_model_inst (.CORE_CLK(CORE_CLK), .NRST(NRST), .FETCH_READY(FETCH_READY),
      .offer(offer), .word(word), .FETCH_VALID(FETCH_VALID), .FETCH_DATA(FETCH_DATA));
   // Strobes stay up so calls run back to back
   task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge CORE_CLK);
      REG_WR <= wr;
      REG_RD <= !wr;
      REG_ADDR <= a;
      REG_WDATA <= d;
      PIX_ADVANCE <= 1'b0;
      if (!wr) exp_q.push_back(d);
   endtask : acc
   task automatic px(input logic ovl, input logic [3:0] scr, input logic [7:0] e);
      @(posedge CORE_CLK);
      REG_WR <= 1'b0;
      REG_RD <= 1'b0;
      PIX_ADVANCE <= 1'b1;
      OVL_ACTIVE <= ovl;
      SCREEN_SHADE <= scr;
      exp_q.push_back(e);
   endtask : px
   function automatic logic [7:0] dec(input logic [1:0] m, input logic [1:0] p, input logic [3:0] c);
      if (m[1]) return {4'h0, p == 2'd0 ? sh[0] : p == 2'd1 ? sh[1] : p == 2'd2 ? c : ~c};
      return {4'h0, (m[0] && p == 2'd0) ? c : sh[p]};
   endfunction : dec
   task automatic end_of_test;
      if (errors == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test
   always @(posedge CORE_CLK) begin
      if (rd_seen || px_seen) begin
         got = rd_seen ? REG_RDATA : {4'h0, PIX_SHADE};
         samples_checked++;
         if (got !== exp_q[0]) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp_q[0]);
         end
         void'(exp_q.pop_front());
      end
      rd_seen <= REG_RD;
      px_seen <= PIX_ADVANCE;
      cycles++;
      if (cycles == 2000) begin
         errors++;
         end_of_test();
      end
   end
   initial begin
      void'($urandom(32'h664830d0));
      repeat (5) @(posedge CORE_CLK);
      NRST <= 1'b1;
      for (int i = 0; i < 4; i++) acc(1'b0, OFS_COLOR_ZERO | 8'(i), 8'h00);
      for (int i = 0; i < 4; i++) begin
         sh[i] = 4'($urandom);
         acc(1'b1, OFS_COLOR_ZERO | 8'(i), {4'($urandom), sh[i]});
         acc(1'b0, OFS_COLOR_ZERO | 8'(i), {4'h0, sh[i]});
      end
      acc(1'b1, 8'h10, 8'hFF);
      acc(1'b0, 8'h10, 8'h00);
      for (int m = 0; m < 4; m++) begin
         acc(1'b1, OFS_FUNCTION, 8'(m) | 8'h0C);
         acc(1'b0, OFS_FUNCTION, 8'(m) | 8'h0C);
         acc(1'b0, OFS_STATUS, 8'h00);
         acc(1'b1, OFS_ENABLE, 8'h01);
         acc(1'b0, OFS_STATUS, {6'h0, m[1], 1'b1});
         w = $urandom;
         @(posedge CORE_CLK);
         REG_RD <= 1'b0;
         REG_WR <= 1'b0;
         offer <= 1'b1;
         word <= w;
         @(posedge CORE_CLK);
         offer <= 1'b0;
         @(posedge CORE_CLK);
         for (int k = 0; k < 20 && FETCH_VALID === 1'b1; k++) @(posedge CORE_CLK);
         // Word held and no pixel consumed yet, so no new fetch wanted
         samples_checked++;
         if (FETCH_READY !== 1'b0) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, FETCH_READY, 1'b0);
         end
         for (int n = 0; n < (m[1] ? 16 : 8); n++) begin
            s = 4'($urandom);
            px(1'b1, s, dec(m[1:0], n < 8 ? {w[15-n], w[7-n]} : {w[39-n], w[31-n]}, s));
         end
         px(m[0], s, {4'h0, s});
         acc(1'b1, OFS_ENABLE, 8'h00);
      end
      @(posedge CORE_CLK);
      REG_WR <= 1'b0;
      repeat (3) @(posedge CORE_CLK);
      end_of_test();
   end
endmodule : tb_top
